// ### hdl/charger_option_control_bits.sv
// Charger option bytes with their serial target port and control outputs.
// Assumes open-drain bus pins resolved outside; no clock stretching is done.
`timescale 1ns/1ps
`default_nettype none
module charger_option_control_bits #(
   parameter logic [6:0] TARGET_ADDR = charger_option_pkg::TARGET_ADDR_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic battery_below_min_system,
   input wire logic multi_cell_pack,
   input wire logic [12:0] charge_current_setting_ma,
   input wire logic max_charge_voltage_valid,
   input wire logic charge_current_valid,
   input wire logic input_current_regulation_auto_off,
   output logic precharge_linear_mode_enable,
   output logic precharge_active,
   output logic [12:0] precharge_current_ma,
   output logic battery_switch_full_on,
   output logic regulate_from_max_charge_voltage,
   output logic input_current_regulation_enable,
   output logic charge_block,
   output logic charge_enable,
   output logic low_power_mode,
   output logic battery_current_buffer_enable,
   output logic low_power_proc_hot_select_rail
);
   import charger_option_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      link_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic rw;
      logic ptr_done;
      logic oe;
      logic scl_d;
      logic sda_d;
      logic [7:0] opt0_low;
      logic [7:0] opt0_high;
      logic [15:0] opt1;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;
   logic [1:0] pins_sync;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [12:0] clamp_ma;
   logic [7:0] rd_byte;

   sync2 #(.WIDTH(2), .RESET_VAL(2'h3)) u_pin_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .async_in({scl_in, sda_in}),
      .sync_out(pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];
   assign scl_rise = scl_s & ~cur_ff.scl_d;
   assign scl_fall = ~scl_s & cur_ff.scl_d;
   assign start_seen = scl_s & cur_ff.scl_d & cur_ff.sda_d & ~sda_s;
   assign stop_seen = scl_s & cur_ff.scl_d & ~cur_ff.sda_d & sda_s;

   // ************************************************************
   // Register read mux
   // ************************************************************
   function automatic logic [7:0] read_byte(input state_t s, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         OPT0_LOW_ADDR: r = s.opt0_low;
         OPT0_HIGH_ADDR: r = s.opt0_high;
         OPT1_LOW_ADDR: r = s.opt1[7:0];
         OPT1_HIGH_ADDR: r = s.opt1[15:8];
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Named so its top bit can be picked without selecting a call result
   assign rd_byte = read_byte(cur_ff, cur_ff.ptr);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.scl_d = scl_s;
      nxt_cur.sda_d = sda_s;
      if (stop_seen) begin
         nxt_cur.st = IDLE;
         nxt_cur.oe = 1'b0;
      end else if (start_seen) begin
         nxt_cur.st = ADDR;
         nxt_cur.bitcnt = 4'h0;
         nxt_cur.ptr_done = 1'b0;
         nxt_cur.oe = 1'b0;
      end else if (scl_rise) begin
         case (cur_ff.st)
            ADDR, PTR, WDATA: begin
               nxt_cur.shreg = {cur_ff.shreg[6:0], sda_s};
               nxt_cur.bitcnt = cur_ff.bitcnt + 4'h1;
            end
            RDATA: begin
               nxt_cur.bitcnt = cur_ff.bitcnt + 4'h1;
            end
            RACK: begin
               // A not-acknowledge ends the read burst
               if (sda_s) begin
                  nxt_cur.st = IDLE;
               end
            end
            default: begin
               nxt_cur.st = cur_ff.st;
            end
         endcase
      end else if (scl_fall) begin
         case (cur_ff.st)
            ADDR: begin
               if (cur_ff.bitcnt == BITS_PER_BYTE) begin
                  if (cur_ff.shreg[7:1] == TARGET_ADDR) begin
                     nxt_cur.st = ACK;
                     nxt_cur.oe = 1'b1;
                     nxt_cur.rw = cur_ff.shreg[0];
                  end else begin
                     nxt_cur.st = IDLE;
                  end
               end
            end
            PTR, WDATA: begin
               if (cur_ff.bitcnt == BITS_PER_BYTE) begin
                  nxt_cur.st = ACK;
                  nxt_cur.oe = 1'b1;
                  if (cur_ff.st == PTR) begin
                     nxt_cur.ptr = cur_ff.shreg;
                     nxt_cur.ptr_done = 1'b1;
                  end else begin
                     nxt_cur.ptr = cur_ff.ptr + 8'h01;
                     // Writes to unmapped addresses are dropped
                     case (cur_ff.ptr)
                        OPT0_LOW_ADDR: nxt_cur.opt0_low = cur_ff.shreg;
                        OPT0_HIGH_ADDR: nxt_cur.opt0_high = cur_ff.shreg;
                        OPT1_LOW_ADDR: nxt_cur.opt1[7:0] = cur_ff.shreg;
                        OPT1_HIGH_ADDR: nxt_cur.opt1[15:8] = cur_ff.shreg;
                        default: nxt_cur.ptr = cur_ff.ptr + 8'h01;
                     endcase
                  end
               end
            end
            ACK, RACK: begin
               nxt_cur.bitcnt = 4'h0;
               if (cur_ff.rw) begin
                  nxt_cur.st = RDATA;
                  nxt_cur.shreg = rd_byte;
                  nxt_cur.oe = ~rd_byte[7];
                  nxt_cur.ptr = cur_ff.ptr + 8'h01;
               end else begin
                  nxt_cur.st = cur_ff.ptr_done ? WDATA : PTR;
                  nxt_cur.oe = 1'b0;
               end
            end
            RDATA: begin
               if (cur_ff.bitcnt == BITS_PER_BYTE) begin
                  nxt_cur.st = RACK;
                  nxt_cur.oe = 1'b0;
               end else begin
                  nxt_cur.shreg = {cur_ff.shreg[6:0], 1'b0};
                  nxt_cur.oe = ~cur_ff.shreg[6];
               end
            end
            default: begin
               nxt_cur.st = cur_ff.st;
            end
         endcase
      end
      // Charger event overrides a host write in the same cycle
      if (input_current_regulation_auto_off) begin
         nxt_cur.opt0_low[REGULATION_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cur_ff.st <= IDLE;
         cur_ff.bitcnt <= 4'h0;
         cur_ff.shreg <= 8'h00;
         cur_ff.ptr <= 8'h00;
         cur_ff.rw <= 1'b0;
         cur_ff.ptr_done <= 1'b0;
         cur_ff.oe <= 1'b0;
         cur_ff.scl_d <= 1'b1;
         cur_ff.sda_d <= 1'b1;
         cur_ff.opt0_low <= OPT0_LOW_RESET;
         cur_ff.opt0_high <= OPT0_HIGH_RESET;
         cur_ff.opt1 <= OPT1_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ************************************************************
   // Control outputs
   // ************************************************************
   assign sda_out = 1'b0;
   assign sda_oe = cur_ff.oe;
   assign precharge_linear_mode_enable = cur_ff.opt0_low[LINEAR_MODE_BIT];
   assign clamp_ma = multi_cell_pack ? PRECHARGE_CLAMP_MULTI_MA : PRECHARGE_CLAMP_SINGLE_MA;
   assign precharge_active = battery_below_min_system & precharge_linear_mode_enable;
   assign precharge_current_ma = (charge_current_setting_ma > clamp_ma) ? clamp_ma
                                 : charge_current_setting_ma;
   assign battery_switch_full_on = ~precharge_linear_mode_enable;
   assign regulate_from_max_charge_voltage = ~precharge_linear_mode_enable;
   assign input_current_regulation_enable = cur_ff.opt0_low[REGULATION_BIT];
   assign charge_block = cur_ff.opt0_low[CHARGE_BLOCK_BIT];
   assign charge_enable = ~charge_block & max_charge_voltage_valid & charge_current_valid;
   assign low_power_mode = cur_ff.opt0_high[LOW_POWER_BIT];
   assign battery_current_buffer_enable = cur_ff.opt1[BUFFER_ENABLE_BIT] & ~low_power_mode;
   // Host must keep this off with an adapter present; not checked here
   assign low_power_proc_hot_select_rail =
      (cur_ff.opt1[PROC_HOT_MSB:PROC_HOT_LSB] == PROC_HOT_RAIL);
endmodule
`default_nettype wire

// ### shared/charger_option_pkg.sv
// Register map, field positions and reset values of the charger option bytes.
// Assumes byte-wide registers reached over a two-wire serial target port.
package charger_option_pkg;
   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [7:0] OPT0_LOW_ADDR = 8'h00;
   localparam logic [7:0] OPT0_HIGH_ADDR = 8'h01;
   localparam logic [7:0] OPT1_LOW_ADDR = 8'h30;
   localparam logic [7:0] OPT1_HIGH_ADDR = 8'h31;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] OPT0_LOW_RESET = 8'h0e;
   localparam logic [7:0] OPT0_HIGH_RESET = 8'h00;
   localparam logic [15:0] OPT1_RESET = 16'h0211;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LINEAR_MODE_BIT = 2;
   localparam int REGULATION_BIT = 1;
   localparam int CHARGE_BLOCK_BIT = 0;
   localparam int LOW_POWER_BIT = 7;
   localparam int BUFFER_ENABLE_BIT = 15;
   localparam int PROC_HOT_MSB = 14;
   localparam int PROC_HOT_LSB = 13;
   // ************************************************************
   // Field codes and limits
   // ************************************************************
   localparam logic [1:0] PROC_HOT_OFF = 2'h0;
   localparam logic [1:0] PROC_HOT_RAIL = 2'h2;
   localparam logic [12:0] PRECHARGE_CLAMP_MULTI_MA = 13'h0180;
   localparam logic [12:0] PRECHARGE_CLAMP_SINGLE_MA = 13'h07d0;
   localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h2a;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [2:0] {IDLE, ADDR, ACK, PTR, WDATA, RDATA, RACK} link_state_t;
endpackage

// ### hdl/sync2.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the pins are slow compared to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// ### testbench/charger_option_control_bits_chk.sv
// Assertions on the charger option control outputs.
// Assumes it is bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module charger_option_control_bits_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic sda_oe,
   input wire logic battery_below_min_system,
   input wire logic max_charge_voltage_valid,
   input wire logic charge_current_valid,
   input wire logic input_current_regulation_auto_off,
   input wire logic precharge_linear_mode_enable,
   input wire logic precharge_active,
   input wire logic battery_switch_full_on,
   input wire logic input_current_regulation_enable,
   input wire logic charge_block,
   input wire logic charge_enable,
   input wire logic low_power_mode,
   input wire logic battery_current_buffer_enable
);
   // ****
   // Assertions
   // ****
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   precharge_linear_a: assert property (
      precharge_active == (battery_below_min_system && precharge_linear_mode_enable))
      else $error("precharge active wrong");
   switch_on_a: assert property (battery_switch_full_on == !precharge_linear_mode_enable)
      else $error("battery switch wrong");
   auto_off_clear_a: assert property (input_current_regulation_auto_off |=> !input_current_regulation_enable)
      else $error("regulation enable not cleared");
   charge_start_a: assert property (
      charge_enable == (!charge_block && max_charge_voltage_valid && charge_current_valid))
      else $error("charge enable wrong");
   low_power_buf_a: assert property (low_power_mode |-> !battery_current_buffer_enable)
      else $error("buffer on in low power");
   reset_defaults_a: assert property ($rose(nrst) |-> precharge_linear_mode_enable &&
      input_current_regulation_enable && !charge_block && !battery_current_buffer_enable && !low_power_mode)
      else $error("reset values wrong");
   // The linear, block and low power bits move only at a host byte ACK
   host_write_only_a: assert property (
      !$stable({low_power_mode, charge_block, precharge_linear_mode_enable}) |-> ##[0:2] sda_oe)
      else $error("register changed outside write");
   regulation_set_a: assert property ($rose(input_current_regulation_enable) |-> ##[0:2] sda_oe)
      else $error("regulation enable set outside write");
endmodule
bind charger_option_control_bits charger_option_control_bits_chk charger_option_control_bits_chk_inst (
   .clk_sys, .nrst, .sda_oe, .battery_below_min_system, .max_charge_voltage_valid, .charge_current_valid,
   .input_current_regulation_auto_off, .precharge_linear_mode_enable, .precharge_active,
   .battery_switch_full_on, .input_current_regulation_enable, .charge_block, .charge_enable,
   .low_power_mode, .battery_current_buffer_enable
);
`default_nettype wire

// ### testbench/i2c_host_model.sv
// Serial host model in place of the embedded controller.
// Assumes SDA is open drain with a pull-up resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   input wire logic clk_sys,
   input wire logic sda_line,
   output var logic scl,
   output var logic sda_low,
   output var logic acked
);
   // ****
   // Bus phases
   // ****
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      acked = 1'b0;
   end
   // SDA moves a clock after SCL so no false START or STOP
   task automatic set(input logic s, input logic d);
      scl = s;
      @(negedge clk_sys);
      sda_low = d;
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic bit_io(input logic b, output logic r);
      set(1'b0, !b);
      set(1'b1, !b);
      r = sda_line;
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic a);
      logic rb;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], rb);
         r = {r[6:0], rb};
      end
      bit_io(1'b1, a);
   endtask
   task automatic start();
      set(1'b0, 1'b0);
      set(1'b1, 1'b0);
      set(1'b1, 1'b1);
   endtask
   task automatic stop();
      set(1'b0, 1'b1);
      set(1'b1, 1'b1);
      set(1'b1, 1'b0);
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] v);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      xfer({dev, 1'b0}, r, a0);
      xfer(p, r, a1);
      xfer(v, r, a2);
      stop();
      acked = !(a0 || a1 || a2);
   endtask
   // Single byte read, ended by NACK
   task automatic rd(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] v);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      start();
      xfer({dev, 1'b0}, r, a0);
      xfer(p, r, a1);
      start();
      xfer({dev, 1'b1}, r, a2);
      xfer(8'hff, v, a3);
      stop();
      acked = !(a0 || a1 || a2);
   endtask
endmodule
`default_nettype wire

// ### testbench/charger_option_control_bits_bench.sv
// Self-checking bench for the charger option bytes.
// Assumes the host model drives the serial port.
`timescale 1ns/1ps
`default_nettype none
module charger_option_control_bits_bench;
   localparam logic [6:0] DEV = 7'h2a;
   logic clk_sys = 1'b0, nrst = 1'b0, below = 1'b0, multi = 1'b0, mv = 1'b0, cv = 1'b0, aoff = 1'b0;
   logic [12:0] cur = 13'h0000, pcur;
   logic scl, sda_low, acked, sda_out, sda_oe, lin, act, sw, rmax, icr, blk, en, lpm, bufe, rail;
   int err_total = 0, samples_checked = 0;
   wire logic sda_line = !(sda_low || (sda_oe && !sda_out));
   wire logic [12:0] st = {3'h0, lin, act, sw, rmax, icr, blk, en, lpm, bufe, rail};
   charger_option_control_bits #(.TARGET_ADDR(DEV)) charger_option_control_bits_inst (
      .clk_sys, .nrst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .battery_below_min_system(below),
      .multi_cell_pack(multi), .charge_current_setting_ma(cur), .max_charge_voltage_valid(mv),
      .charge_current_valid(cv), .input_current_regulation_auto_off(aoff), .precharge_linear_mode_enable(lin),
      .precharge_active(act), .precharge_current_ma(pcur), .battery_switch_full_on(sw),
      .regulate_from_max_charge_voltage(rmax), .input_current_regulation_enable(icr), .charge_block(blk),
      .charge_enable(en), .low_power_mode(lpm), .battery_current_buffer_enable(bufe),
      .low_power_proc_hot_select_rail(rail)
   );
   i2c_host_model i2c_host_model_inst (.clk_sys, .sda_line, .scl, .sda_low, .acked);
   always #2.5 clk_sys = ~clk_sys;
   // ****
   // Scenarios
   // ****
   // f = linear, regulation, block, low power, buffer bit, rail select
   function automatic logic [12:0] ex(input logic [5:0] f);
      return {3'h0, f[5], below && f[5], !f[5], !f[5], f[4], f[3], !f[3] && mv && cv, f[2], f[1] && !f[2], f[0]};
   endfunction
   task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      i2c_host_model_inst.wr(DEV, p, v);
      @(negedge clk_sys);
   endtask
   task automatic rdc(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] v;
      i2c_host_model_inst.rd(DEV, p, v);
      chk("register", {5'h00, e}, {5'h00, v});
   endtask
   task automatic t_reset();
      rdc(8'h00, 8'h0e);
      rdc(8'h01, 8'h00);
      rdc(8'h30, 8'h11);
      rdc(8'h31, 8'h02);
      chk("status", ex(6'b110000), st);
      $display("reset test done");
   endtask
   task automatic t_linear();
      wr(8'h00, 8'h0a);
      chk("status", ex(6'b010000), st);
      below = 1'b1;
      multi = 1'b1;
      cur = 13'h0181;
      wr(8'h00, 8'h0e);
      chk("status", ex(6'b110000), st);
      chk("current", 13'h0180, pcur);
      multi = 1'b0;
      cur = 13'h07d1;
      @(negedge clk_sys);
      chk("current", 13'h07d0, pcur);
      cur = 13'h03e8;
      @(negedge clk_sys);
      chk("current", 13'h03e8, pcur);
      $display("linear test done");
   endtask
   task automatic t_regulation();
      wr(8'h00, 8'h0c);
      chk("status", ex(6'b100000), st);
      wr(8'h00, 8'h0e);
      chk("status", ex(6'b110000), st);
      aoff = 1'b1;
      @(negedge clk_sys);
      aoff = 1'b0;
      @(negedge clk_sys);
      chk("status", ex(6'b100000), st);
      rdc(8'h00, 8'h0c);
      $display("regulation test done");
   endtask
   task automatic t_block();
      mv = 1'b1;
      cv = 1'b1;
      wr(8'h00, 8'h0d);
      chk("status", ex(6'b101000), st);
      wr(8'h00, 8'h0c);
      chk("status", ex(6'b100000), st);
      cv = 1'b0;
      @(negedge clk_sys);
      chk("status", ex(6'b100000), st);
      $display("block test done");
   endtask
   task automatic t_option_one();
      wr(8'h31, 8'hc2);
      chk("status", ex(6'b100011), st);
      wr(8'h01, 8'h80);
      chk("status", ex(6'b100111), st);
      rdc(8'h31, 8'hc2);
      wr(8'h31, 8'ha2);
      chk("status", ex(6'b100110), st);
      wr(8'h31, 8'he2);
      chk("status", ex(6'b100110), st);
      rdc(8'h31, 8'he2);
      wr(8'h30, 8'h55);
      i2c_host_model_inst.wr(7'h2b, 8'h30, 8'haa);
      chk("ack", 13'h0000, {12'h000, acked});
      rdc(8'h30, 8'h55);
      $display("option one test done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Some 20 bus transfers of at most 1200 clocks each
   initial begin
      #300000;
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_reset();
      t_linear();
      t_regulation();
      t_block();
      t_option_one();
      end_of_test();
   end
endmodule
`default_nettype wire
